// ### include/rsc_pkg.sv
package rsc_pkg;
  // ------------------------------------------------------------
  // Register byte offsets
  // ------------------------------------------------------------
  localparam logic [7:0] OFS_CONV_CTRL  = 8'h00;
  localparam logic [7:0] OFS_DISCHARGE  = 8'h04;
  localparam logic [7:0] OFS_REG_CTRL   = 8'h08;
  localparam logic [7:0] OFS_LIN_VOLT   = 8'h0c;
  localparam logic [7:0] OFS_FAULT      = 8'h10;
  localparam logic [7:0] OFS_STATUS     = 8'h14;
  localparam logic [7:0] OFS_BUCK3_VSET = 8'h18;

  // ------------------------------------------------------------
  // Field positions and reset values
  // ------------------------------------------------------------
  localparam int          LOW_RIPPLE_BIT  = 3;
  localparam logic [7:0]  CONV_CTRL_RST   = 8'h00;
  localparam logic [2:0]  DISCHARGE_RST   = 3'h0;
  localparam logic [1:0]  REG_CTRL_RST    = 2'h3;
  localparam logic [7:0]  LIN_VOLT_RST    = 8'h00;

  // Default output setting codes in millivolts, per select level
  localparam logic [11:0] B1_DEF_LO = 12'hbb8;
  localparam logic [11:0] B1_DEF_HI = 12'hce4;
  localparam logic [11:0] B2_DEF_LO = 12'h708;
  localparam logic [11:0] B2_DEF_HI = 12'h9c4;
  localparam logic [11:0] B3_DEF_LO = 12'h514;
  localparam logic [11:0] B3_DEF_HI = 12'h60e;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_NS        = 100;
  localparam int BIAS_US       = 170;
  localparam int SOFTSTART_US  = 750;
  localparam int DEBOUNCE_MS   = 30;
  localparam int RESET_MS_1NF  = 100;
  localparam int BIAS_CYC      = (BIAS_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int SOFTSTART_CYC = (SOFTSTART_US * 1000) / CLK_NS;
  localparam int DEBOUNCE_CYC  = (DEBOUNCE_MS * 1000000 + CLK_NS - 1) / CLK_NS;
  localparam int RESET_CYC_1NF = (RESET_MS_1NF * 1000000 + CLK_NS - 1) / CLK_NS;

  typedef enum logic [1:0] {RSC_OFF, RSC_BIAS, RSC_RAMP, RSC_RUN} rsc_buck_e;
endpackage

// ### rtl/rsc_buck_seq.sv
`timescale 1ns/1ns
module rsc_buck_seq #(
  parameter int BIAS_CYC = rsc_pkg::BIAS_CYC,
  parameter int RAMP_CYC = rsc_pkg::SOFTSTART_CYC
) (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // Control
  input  wire logic        run_en,
  input  wire logic        dis_allow,
  input  wire logic        headroom_low,
  input  wire logic [6:0]  precharge_pct,
  // Converter drive
  output logic             switching,
  output logic             full_duty,
  output logic             discharge_on,
  output logic             in_reg,
  output logic             ramping
);
  localparam int CW = 24;
  rsc_pkg::rsc_buck_e state_r, state_nxt;
  logic [CW-1:0] cnt_r, cnt_nxt;
  logic [CW-1:0] ramp_left;

  // Precharged output skips the matching share of the ramp
  assign ramp_left = CW'((RAMP_CYC * (100 - int'(precharge_pct))) / 100);

  // Bias wait, then ramp, then regulate
  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = (cnt_r != '0) ? cnt_r - 1'b1 : cnt_r;
    if (!run_en) begin
      state_nxt = rsc_pkg::RSC_OFF;
      cnt_nxt   = '0;
    end else begin
      case (state_r)
        rsc_pkg::RSC_OFF: begin
          state_nxt = rsc_pkg::RSC_BIAS;
          cnt_nxt   = CW'(BIAS_CYC - 1);
        end
        rsc_pkg::RSC_BIAS: begin
          if (cnt_r == '0) begin
            state_nxt = rsc_pkg::RSC_RAMP;
            cnt_nxt   = ramp_left;
          end
        end
        rsc_pkg::RSC_RAMP: begin
          if (cnt_r == '0) begin
            state_nxt = rsc_pkg::RSC_RUN;
          end
        end
        default: state_nxt = rsc_pkg::RSC_RUN;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= rsc_pkg::RSC_OFF;
      cnt_r   <= '0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
    end
  end

  // No switching during bias; the enable gate stops a shut-down rail in the same cycle
  assign switching    = run_en && (state_r == rsc_pkg::RSC_RAMP || state_r == rsc_pkg::RSC_RUN) && !headroom_low;
  assign full_duty    = run_en && (state_r == rsc_pkg::RSC_RUN) && headroom_low;
  assign discharge_on = !run_en && dis_allow;
  assign in_reg       = (state_r == rsc_pkg::RSC_RUN);
  assign ramping      = (state_r == rsc_pkg::RSC_RAMP);

  // Six quiet samples hold for any bias count of five or more
  a_bias_wait: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(run_en) |-> !switching [*6]) else $error("switching during bias");
  a_full_duty: assert property (@(posedge hclk) disable iff (!hresetn)
    full_duty |-> !switching && run_en) else $error("full duty while switching");
  a_dis_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    (!run_en && dis_allow) |-> discharge_on && !switching) else $error("discharge not held");
  c_reach_run: cover property (@(posedge hclk) disable iff (!hresetn) $rose(in_reg));
endmodule

// ### rtl/rsc_timer.sv
`timescale 1ns/1ns
module rsc_timer #(
  parameter int CYC = 16
) (
  // Clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // Condition and result
  input  wire logic cond,
  output logic      done
);
  localparam int CW = $clog2(CYC + 1);
  logic [CW-1:0] cnt_r;

  // Restart whenever the condition drops before expiry
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_r <= '0;
    end else if (!cond) begin
      cnt_r <= '0;
    end else if (cnt_r != CW'(CYC)) begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  assign done = cond && (cnt_r == CW'(CYC));

  a_tmr_restart: assert property (@(posedge hclk) disable iff (!hresetn)
    !cond |=> !done) else $error("timer not restarted");
endmodule

// ### rtl/rsc_top.sv
// Overview of operation
// - Control bit 3 selects low-ripple PFM for all three converters.
// - Converter waits the bias delay after enable before switching.
// - Soft-start ramp lasts 750 us, shortened by output precharge.
// - Discharge is off after reset, enabled per converter by register bit.
// - Enabled discharge load stays while converter is disabled, released on enable.
// - Each rail flags fault below 10 percent, clears above 5 percent band.
// - Any rail fault raises interrupt; flags readable in fault register.
// - Disabled regulator's comparator is ignored and flag reads good.
// - One pin enables both linear regulators; register may disable each.
// - Lockout or overtemperature shuts down all five regulators.
// - Supply lockout disables every converter and linear regulator.
// - Each converter follows its own enable pin.
// - Default voltage of each converter follows its select pin.
// - Warm reset returns only converter three's setting to default.
// - Warm reset input is debounced before use.
// - Reset output low at power-up and while backup rail is low, then timed.
// - Reset hold time scales with timing capacitor, 100 ms per nF.
// - Warm reset also drives timed reset output low.
// - Low headroom in regulation forces full duty with high side on.
// - Debounce needs 30 ms of stable input.
// - Timed reset low starts when backup rail is good.
// - Converter three default also on backup low, lockout, reset, or both off.
//
// Decided for this implementation: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ns
module rsc_top #(
  parameter int DEBOUNCE_CYC = rsc_pkg::DEBOUNCE_CYC,
  parameter int RESET_CYC    = rsc_pkg::RESET_CYC_1NF,
  parameter int BIAS_CYC     = rsc_pkg::BIAS_CYC,
  parameter int RAMP_CYC     = rsc_pkg::SOFTSTART_CYC
) (
  // AHB-Lite clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Host pins
  input  wire logic        buck1_enable_pin,
  input  wire logic        buck2_enable_pin,
  input  wire logic        buck3_enable_pin,
  input  wire logic        linear_reg_enable_pin,
  input  wire logic        buck1_default_select,
  input  wire logic        buck2_default_select,
  input  wire logic        buck3_default_select,
  input  wire logic        warm_reset_in,
  output logic             system_reset_out_n,
  output logic             rail_fault_irq,
  // Analog monitors, rising good thresholds already applied
  input  wire logic        supply_lockout,
  input  wire logic        thermal_shutdown,
  input  wire logic        backup_rail_good,
  input  wire logic [4:0]  rail_below_10pct,
  input  wire logic [4:0]  rail_above_5pct,
  input  wire logic [2:0]  headroom_low,
  input  wire logic [6:0]  precharge_pct,
  input  wire logic [3:0]  reset_timing_cap,
  // Converter and regulator drive
  output logic [2:0]       buck_switching,
  output logic [2:0]       buck_full_duty,
  output logic [2:0]       buck_discharge,
  output logic [2:0]       buck_ramping,
  output logic             low_ripple_pfm,
  output logic [1:0]       linear_enable,
  output logic [11:0]      buck1_vset,
  output logic [11:0]      buck2_vset,
  output logic [11:0]      buck3_vset_out
);
  // ------------------------------------------------------------
  // Registers and flags
  // ------------------------------------------------------------
  logic [7:0]  conv_ctrl_r;
  logic [2:0]  discharge_ctrl_r;
  logic [1:0]  reg_ctrl_r;
  logic [7:0]  linear_voltage_r;
  logic [11:0] buck3_vset_r;
  logic [4:0]  fault_r;
  logic        wr_pend_r;
  logic [7:0]  wr_addr_r;
  logic [31:0] hrdata_r;

  // ------------------------------------------------------------
  // Enables and shutdown
  // ------------------------------------------------------------
  logic       shutdown;
  logic [2:0] buck_run;
  logic [4:0] rail_on;
  logic [2:0] buck_in_reg;

  // Lockout or overtemperature kills all five rails
  assign shutdown      = supply_lockout || thermal_shutdown;
  assign buck_run      = {buck3_enable_pin, buck2_enable_pin, buck1_enable_pin} & {3{!shutdown}};
  assign linear_enable = {2{linear_reg_enable_pin && !shutdown}} & reg_ctrl_r;
  assign rail_on       = {linear_enable, buck_run};
  assign low_ripple_pfm = conv_ctrl_r[rsc_pkg::LOW_RIPPLE_BIT];

  // ------------------------------------------------------------
  // Converter sequencers
  // ------------------------------------------------------------
  // One sequencer per converter
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_buck
      rsc_buck_seq #(.BIAS_CYC(BIAS_CYC), .RAMP_CYC(RAMP_CYC)) u_seq (
        .hclk          (hclk),
        .hresetn       (hresetn),
        .run_en        (buck_run[gi]),
        .dis_allow     (discharge_ctrl_r[gi]),
        .headroom_low  (headroom_low[gi]),
        .precharge_pct (precharge_pct),
        .switching     (buck_switching[gi]),
        .full_duty     (buck_full_duty[gi]),
        .discharge_on  (buck_discharge[gi]),
        .in_reg        (buck_in_reg[gi]),
        .ramping       (buck_ramping[gi])
      );
    end
  endgenerate

  // ------------------------------------------------------------
  // Default voltages and warm reset
  // ------------------------------------------------------------
  logic [11:0] buck3_default;
  logic        warm_reset_db;
  logic        reset_timer_done;
  logic        buck3_restore;

  // Pin-selected defaults
  assign buck1_vset    = buck1_default_select ? rsc_pkg::B1_DEF_HI : rsc_pkg::B1_DEF_LO;
  assign buck2_vset    = buck2_default_select ? rsc_pkg::B2_DEF_HI : rsc_pkg::B2_DEF_LO;
  assign buck3_default = buck3_default_select ? rsc_pkg::B3_DEF_HI : rsc_pkg::B3_DEF_LO;
  assign buck3_vset_out = buck3_vset_r;

  // Warm reset must hold steady for the filter time
  rsc_timer #(.CYC(DEBOUNCE_CYC)) u_debounce (
    .hclk    (hclk),
    .hresetn (hresetn),
    .cond    (warm_reset_in),
    .done    (warm_reset_db)
  );

  // ------------------------------------------------------------
  // Reset output
  // ------------------------------------------------------------
  // Timed hold restarts on any low backup rail or warm reset
  logic        hold_cond;
  logic [31:0] hold_cnt_r;
  logic [31:0] hold_target;
  assign hold_cond   = backup_rail_good && !warm_reset_db;
  assign hold_target = 32'(RESET_CYC) * 32'(reset_timing_cap);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hold_cnt_r <= '0;
    end else if (!hold_cond) begin
      hold_cnt_r <= '0;
    end else if (hold_cnt_r < hold_target) begin
      hold_cnt_r <= hold_cnt_r + 1'b1;
    end
  end
  assign reset_timer_done = hold_cond && (hold_cnt_r >= hold_target);

  // Low from power-up until the hold expires
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      system_reset_out_n <= 1'b0;
    end else begin
      system_reset_out_n <= reset_timer_done;
    end
  end

  // Only converter three's setting returns to default
  assign buck3_restore = warm_reset_db || !backup_rail_good || supply_lockout ||
                         !system_reset_out_n || (!buck_run[0] && !buck_run[2]);

  // ------------------------------------------------------------
  // Power-good flags
  // ------------------------------------------------------------
  logic [4:0] fault_nxt;
  // Set below 10 percent, clear only past the 5 percent band; off rails read good
  assign fault_nxt = rail_on & ((fault_r & ~rail_above_5pct) | rail_below_10pct);
  assign rail_fault_irq = |fault_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fault_r <= '0;
    end else begin
      fault_r <= fault_nxt;
    end
  end

  // ------------------------------------------------------------
  // AHB-Lite slave, zero wait states
  // ------------------------------------------------------------
  logic       addr_valid;
  logic       wr_req;
  logic [7:0] rd_addr;
  logic [31:0] rd_mux;
  assign addr_valid = hsel && hready && htrans[1];
  assign wr_req     = addr_valid && hwrite;
  assign rd_addr    = haddr;
  assign hreadyout  = 1'b1;
  assign hresp      = 1'b0;
  assign hrdata     = hrdata_r;

  // Read decode; unmapped words read zero
  always_comb begin
    if (rd_addr == rsc_pkg::OFS_CONV_CTRL) begin
      rd_mux = {24'h000000, conv_ctrl_r};
    end else if (rd_addr == rsc_pkg::OFS_DISCHARGE) begin
      rd_mux = {29'h0, discharge_ctrl_r};
    end else if (rd_addr == rsc_pkg::OFS_REG_CTRL) begin
      rd_mux = {30'h0, reg_ctrl_r};
    end else if (rd_addr == rsc_pkg::OFS_LIN_VOLT) begin
      rd_mux = {24'h000000, linear_voltage_r};
    end else if (rd_addr == rsc_pkg::OFS_FAULT) begin
      rd_mux = {27'h0, fault_r};
    end else if (rd_addr == rsc_pkg::OFS_STATUS) begin
      rd_mux = {23'h0, system_reset_out_n, shutdown, buck_ramping, buck_in_reg, buck_full_duty[0]};
    end else if (rd_addr == rsc_pkg::OFS_BUCK3_VSET) begin
      rd_mux = {20'h00000, buck3_vset_r};
    end else begin
      rd_mux = 32'h00000000;
    end
  end

  // Capture address phase; read data is registered into the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      hrdata_r  <= 32'h00000000;
    end else begin
      wr_pend_r <= wr_req;
      wr_addr_r <= haddr;
      if (addr_valid && !hwrite) begin
        hrdata_r <= rd_mux;
      end
    end
  end

  // ------------------------------------------------------------
  // Register writes
  // ------------------------------------------------------------
  // Register writes in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      conv_ctrl_r      <= rsc_pkg::CONV_CTRL_RST;
      discharge_ctrl_r <= rsc_pkg::DISCHARGE_RST;
      reg_ctrl_r       <= rsc_pkg::REG_CTRL_RST;
      linear_voltage_r <= rsc_pkg::LIN_VOLT_RST;
    end else if (wr_pend_r) begin
      if (wr_addr_r == rsc_pkg::OFS_CONV_CTRL) begin
        conv_ctrl_r <= hwdata[7:0];
      end else if (wr_addr_r == rsc_pkg::OFS_DISCHARGE) begin
        discharge_ctrl_r <= hwdata[2:0];
      end else if (wr_addr_r == rsc_pkg::OFS_REG_CTRL) begin
        reg_ctrl_r <= hwdata[1:0];
      end else if (wr_addr_r == rsc_pkg::OFS_LIN_VOLT) begin
        linear_voltage_r <= hwdata[7:0];
      end
    end
  end

  // Converter three setting; restore beats a software write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      buck3_vset_r <= rsc_pkg::B3_DEF_LO;
    end else if (buck3_restore) begin
      buck3_vset_r <= buck3_default;
    end else if (wr_pend_r && wr_addr_r == rsc_pkg::OFS_BUCK3_VSET) begin
      buck3_vset_r <= hwdata[11:0];
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking main_cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // Low-ripple output mirrors its control bit
  a_ripple_bit: assert property (
    low_ripple_pfm == conv_ctrl_r[3]
  ) else $error("low ripple not following bit 3");
  // Nothing switches and no linear runs in shutdown
  a_shutdown_all: assert property (
    shutdown |-> (buck_switching == 3'b000) && (linear_enable == 2'b00)
  ) else $error("rail on in shutdown");
  // Lockout alone already stops every converter
  a_lockout_off: assert property (
    supply_lockout |-> buck_run == 3'b000
  ) else $error("converter on in lockout");
  // Each converter tracks only its own pin
  a_pin_follow: assert property (
    !shutdown |-> buck_run == {buck3_enable_pin, buck2_enable_pin, buck1_enable_pin}
  ) else $error("pin ignored");
  // A low running rail is flagged at the next edge
  a_fault_set: assert property (
    (rail_on[0] && rail_below_10pct[0]) |=> fault_r[0] || !rail_on[0]
  ) else $error("fault not set");
  // A rail back past the band clears its flag
  a_fault_clear: assert property (
    (rail_on[0] && rail_above_5pct[0] && !rail_below_10pct[0]) |=> !fault_r[0]
  ) else $error("fault not cleared");
  // A disabled second rail reads good at the next edge
  a_off_good: assert property (
    !rail_on[1] |=> !fault_r[1] || rail_on[1]
  ) else $error("disabled rail shows fault");
  // Interrupt is the OR of the flags
  a_irq_any: assert property (
    rail_fault_irq == (fault_r != 5'h00)
  ) else $error("irq mismatch");
  // Debounced warm reset pulls the reset output low
  a_warm_low: assert property (
    warm_reset_db |=> !system_reset_out_n
  ) else $error("warm reset not driving reset");
  // A low backup rail holds reset low
  a_backup_low: assert property (
    !backup_rail_good |=> !system_reset_out_n
  ) else $error("reset high with rail low");
  // Warm reset reloads converter three's default
  a_b3_default: assert property (
    $rose(warm_reset_db) |=> buck3_vset_r == $past(buck3_default)
  ) else $error("buck3 not restored");
  // Lockout also reloads converter three's default
  a_b3_lockout: assert property (
    supply_lockout |=> buck3_vset_r == $past(buck3_default)
  ) else $error("buck3 not restored in lockout");

  // Main scenarios worth seeing
  c_warm_reset: cover property ($rose(warm_reset_db));
  c_reset_rel: cover property ($rose(system_reset_out_n));
  c_fault: cover property ($rose(rail_fault_irq));
  c_full_duty: cover property ($rose(buck_full_duty[0]));
endmodule

// ### sim/rsc_host_model.sv
`timescale 1ns/1ns
module rsc_host_model (
  // Clock
  input  wire logic       hclk,
  // Requests from the bench
  input  wire logic [2:0] buck_req,
  input  wire logic       lin_req,
  input  wire logic       warm_req,
  // Pins toward the device
  output logic [2:0]      buck_en,
  output logic            lin_en,
  output logic            warm_rst
);
  // Pins idle low until the first clock edge copies the requests
  initial begin
    buck_en = 3'h0;
    lin_en = 1'b0;
    warm_rst = 1'b0;
  end

  // Host port moves only just after an edge, one cycle behind the request
  always @(posedge hclk) begin
    buck_en  <= buck_req;
    lin_en   <= lin_req;
    warm_rst <= warm_req;
  end
endmodule

// ### sim/tb_regulator_supervisor_control.sv
`timescale 1ns/1ns
module tb_regulator_supervisor_control;
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, rd_phase = 1'b0;
  logic [7:0]  haddr = 8'h00;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2, buck_req = 3'h0, sel = 3'h0, head = 3'h0;
  logic [31:0] hwdata = 32'h0, w = 32'h0;
  logic        lin_req = 1'b0, warm_req = 1'b0, lockout = 1'b0, hot = 1'b0, bkp = 1'b1;
  logic [4:0]  below = 5'h00, above = 5'h1f;
  logic [6:0]  pct = 7'h32;
  logic [3:0]  cap = 4'h1;
  logic [31:0] hrdata;
  logic        hreadyout, hresp, rst_n, irq, lin_en, warm_pin, lrp;
  logic [2:0]  buck_en, sw, fd, dis, ramp;
  logic [1:0]  lin_out;
  logic [11:0] v1, v2, v3;
  logic [31:0] exp_q[$];
  int          bad_count = 0, comparisons = 0, cyc = 0, n;

  // ----------------------------------------
  // Clock, partner and device
  // ----------------------------------------
  initial begin
    forever #50 hclk = ~hclk;
  end

  rsc_host_model host (.hclk, .buck_req, .lin_req, .warm_req, .buck_en, .lin_en, .warm_rst(warm_pin));

  rsc_top #(.DEBOUNCE_CYC(20), .RESET_CYC(30), .BIAS_CYC(5), .RAMP_CYC(10)) dut (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
    .hrdata, .hreadyout, .hresp, .buck1_enable_pin(buck_en[0]), .buck2_enable_pin(buck_en[1]),
    .buck3_enable_pin(buck_en[2]), .linear_reg_enable_pin(lin_en), .buck1_default_select(sel[0]),
    .buck2_default_select(sel[1]), .buck3_default_select(sel[2]), .warm_reset_in(warm_pin),
    .system_reset_out_n(rst_n), .rail_fault_irq(irq), .supply_lockout(lockout), .thermal_shutdown(hot),
    .backup_rail_good(bkp), .rail_below_10pct(below), .rail_above_5pct(above), .headroom_low(head),
    .precharge_pct(pct), .reset_timing_cap(cap), .buck_switching(sw), .buck_full_duty(fd),
    .buck_discharge(dis), .buck_ramping(ramp), .low_ripple_pfm(lrp), .linear_enable(lin_out),
    .buck1_vset(v1), .buck2_vset(v2), .buck3_vset_out(v3));

  // ----------------------------------------
  // Checks, bus tasks and verdict
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Address phase held until hready, then data phase until hready again
  task automatic bus(input logic wr_en, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr_en;
    haddr <= a;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    if (wr_en) hwdata <= d;
    rd_phase <= !wr_en;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd_phase <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask

  // Waits for the reset output to rise, counting cycles
  task automatic wait_rst;
    n = 0;
    while (rst_n !== 1'b1 && n < 200) begin
      @(negedge hclk);
      n++;
    end
  endtask

  task automatic tally_and_finish;
    if (bad_count == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Read data is taken at the edge that closes the data phase
  always @(posedge hclk) begin
    if (rd_phase && hreadyout === 1'b1) begin
      chk("hrdata", exp_q.pop_front(), hrdata);
      chk("hresp", 32'h0, hresp);
    end
  end

  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      tally_and_finish;
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    n = $urandom(32'h9910);
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    wait_rst;
    chk("power_on_hold", 32'h1, n >= 30 && n <= 34);
    rd(rsc_pkg::OFS_CONV_CTRL, 32'h0);
    rd(rsc_pkg::OFS_DISCHARGE, 32'h0);
    rd(rsc_pkg::OFS_REG_CTRL, 32'h3);
    rd(rsc_pkg::OFS_BUCK3_VSET, 32'h514);
    rd(8'h1c, 32'h0);
    // Select pins pick the defaults of converters one and two
    for (int i = 0; i < 2; i++) begin
      @(posedge hclk);
      sel <= {2'h0, i[0]} | {1'b0, i[0], 1'b0};
      @(negedge hclk);
      chk("buck1_vset", i ? 32'hce4 : 32'hbb8, v1);
      chk("buck2_vset", i ? 32'h9c4 : 32'h708, v2);
    end
    // Random control words; low ripple follows bit 3
    repeat (4) begin
      w = $urandom & 32'hff;
      bus(1'b1, rsc_pkg::OFS_CONV_CTRL, w);
      rd(rsc_pkg::OFS_CONV_CTRL, w);
      chk("low_ripple", w[3], lrp);
    end
    // Discharge while off, then bias delay and shortened ramp
    bus(1'b1, rsc_pkg::OFS_DISCHARGE, 32'h7);
    @(negedge hclk);
    chk("discharge_off", 32'h7, dis);
    @(posedge hclk);
    buck_req <= 3'h1;
    n = 0;
    do begin @(negedge hclk); n++; end while (sw[0] !== 1'b1 && n < 50);
    chk("bias_delay", 32'h1, n >= 6 && n <= 9);
    chk("discharge_on", 32'h6, dis);
    n = 0;
    while (ramp[0] === 1'b1 && n < 50) begin @(negedge hclk); n++; end
    chk("ramp_time", 32'h1, n >= 3 && n <= 7);
    @(posedge hclk);
    head <= 3'h1;
    repeat (2) @(negedge hclk);
    chk("full_duty", 32'h1, fd[0]);
    @(posedge hclk);
    head <= 3'h0;
    below <= 5'h03;
    above <= 5'h00;
    repeat (3) @(negedge hclk);
    chk("irq_set", 32'h1, irq);
    rd(rsc_pkg::OFS_FAULT, 32'h1);
    below <= 5'h00;
    rd(rsc_pkg::OFS_FAULT, 32'h1);
    above <= 5'h1f;
    repeat (3) @(negedge hclk);
    chk("irq_clear", 32'h0, irq);
    // One pin enables both linears, the register may drop one
    @(posedge hclk);
    lin_req <= 1'b1;
    repeat (3) @(negedge hclk);
    chk("linear_on", 32'h3, lin_out);
    bus(1'b1, rsc_pkg::OFS_REG_CTRL, 32'h1);
    @(negedge hclk);
    chk("linear_mask", 32'h1, lin_out);
    // Lockout, then overtemperature, shut everything down
    for (int i = 0; i < 2; i++) begin
      @(posedge hclk);
      lockout <= (i == 0);
      hot <= (i == 1);
      repeat (2) @(negedge hclk);
      chk("switch_off", 32'h0, sw);
      chk("linear_off", 32'h0, lin_out);
      chk("discharge_fault", 32'h7, dis);
      @(posedge hclk);
      lockout <= 1'b0;
      hot <= 1'b0;
    end
    // Short warm reset glitch is filtered out
    buck_req <= 3'h5;
    bus(1'b1, rsc_pkg::OFS_BUCK3_VSET, 32'h400);
    warm_req <= 1'b1;
    repeat (10) @(posedge hclk);
    warm_req <= 1'b0;
    n = 1;
    repeat (40) begin @(negedge hclk); if (rst_n !== 1'b1) n = 0; end
    chk("glitch_ignored", 32'h1, n);
    rd(rsc_pkg::OFS_BUCK3_VSET, 32'h400);
    // Held warm reset restores buck3 only and pulls reset low
    @(posedge hclk);
    warm_req <= 1'b1;
    repeat (30) @(negedge hclk);
    chk("warm_reset_low", 32'h0, rst_n);
    rd(rsc_pkg::OFS_BUCK3_VSET, 32'h514);
    rd(rsc_pkg::OFS_CONV_CTRL, w);
    rd(rsc_pkg::OFS_REG_CTRL, 32'h1);
    warm_req <= 1'b0;
    wait_rst;
    chk("warm_hold", 32'h1, n >= 30 && n <= 60);
    // Backup rail drop, then hold scaled by a larger capacitor
    @(posedge hclk);
    cap <= 4'h2;
    bkp <= 1'b0;
    repeat (3) @(negedge hclk);
    chk("backup_low", 32'h0, rst_n);
    @(posedge hclk);
    bkp <= 1'b1;
    wait_rst;
    chk("cap_hold", 32'h1, n >= 60 && n <= 64);
    // Converters one and three both off restore the high default
    bus(1'b1, rsc_pkg::OFS_BUCK3_VSET, 32'h400);
    buck_req <= 3'h0;
    sel <= 3'h4;
    repeat (3) @(negedge hclk);
    rd(rsc_pkg::OFS_BUCK3_VSET, 32'h60e);
    chk("buck3_vset_out", 32'h60e, v3);
    rd(rsc_pkg::OFS_STATUS, 32'h100);
    tally_and_finish;
  end
endmodule
